// ### inc/pmuswp_pkg.sv
// package of constants and carriers for the pmu serial write port
// How it works
// - Interface-select low picks the single-ended serial pins.
// - Differential mode carries frame sync, data and data out as pairs; the clock takes only its p-side pin.
// - Serial logic is woken only by a falling frame sync.
// - Every command frame carries a 29-bit word.
// - Frames work with a free-running or a burst serial clock.
// - A falling active-low frame sync starts a write cycle.
// - The addressed register updates when frame sync rises.
// - Frames longer than 29 bits are accepted; command sits in the last 29.
// - All serial registers are writable except the dac output register.
// - Offset trim defaults to 32768 and gain trim to 65535.
// - Current-sense amplifier gain is selectable between 5 and 10.
// - Busy goes low on any register write until the command completes.
// - While busy is low for reset initialisation, serial activity is ignored.
// - Serial data out is high impedance during power-on or external reset.
package pmuswp_pkg;

  // ------------------------------------------------------------
  // frame layout
  // ------------------------------------------------------------
  localparam int unsigned WORD_BITS = 29;
  localparam int unsigned CNT_W = 6;
  localparam logic [5:0] WORD_BITS_CNT = 6'h1D;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned RB_POS = 28;
  localparam int unsigned ADDR_LSB = 23;
  localparam int unsigned DATA_LSB = 0;

  // ------------------------------------------------------------
  // register addresses carried in the word
  // ------------------------------------------------------------
  localparam logic [4:0] ADDR_SYS_CTRL = 5'h00;
  localparam logic [4:0] ADDR_FIN_X1 = 5'h01;
  localparam logic [4:0] ADDR_GAIN_TRIM = 5'h02;
  localparam logic [4:0] ADDR_OFFSET_TRIM = 5'h03;
  localparam logic [4:0] ADDR_FIN_DAC_OUT = 5'h04;
  localparam int unsigned SYS_GAIN_SEL_POS = 0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] OFFSET_TRIM_RST = 16'h8000;
  localparam logic [15:0] GAIN_TRIM_RST = 16'hFFFF;
  localparam logic [15:0] FIN_X1_RST = 16'h0000;
  localparam logic SENSE_GAIN_RST = 1'h1;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ = 25_000_000;
  localparam int unsigned REF_PERIOD_NS = 1_000_000_000 / REF_CLK_HZ;
  localparam int unsigned LINK_MAX_HZ = 50_000_000;
  localparam int unsigned BUSY_WRITE_NS = 270;
  localparam int unsigned BUSY_WRITE_CYC = BUSY_WRITE_NS / REF_PERIOD_NS;
  localparam int unsigned INIT_US = 600;
  localparam int unsigned INIT_CYC = (INIT_US * 1000) / REF_PERIOD_NS;
  localparam int unsigned CYC_W = 14;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } pmuswp_state_e;

  typedef struct packed {
    logic rb;
    logic [4:0] addr;
    logic [6:0] spare;
    logic [15:0] data;
  } pmuswp_word_s;

  typedef struct packed {
    logic p;
    logic c;
  } pmuswp_diff_s;

  // true level of a pair; an invalid pair reads as low
  function automatic logic pair_level(input pmuswp_diff_s d);
    return d.p & ~d.c;
  endfunction

endpackage

// ### src/pmuswp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module pmuswp_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic d,
  output logic q
);

  logic meta_reg;
  logic q_reg;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule // pmuswp_sync
`default_nettype wire

// ### src/pmuswp_top.sv
// serial write port: link shifter, frame capture, trim registers, busy
`timescale 1ns/10ps
`default_nettype none
module pmuswp_top #(
  parameter int unsigned INIT_CYCLES = pmuswp_pkg::INIT_CYC
) (
  // reference clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // interface select strap
  input wire logic if_sel,
  // single-ended link
  input wire logic sclk_se,
  input wire logic fsync_se_n,
  input wire logic serial_in_se,
  // differential link
  input wire logic sclk_d_p,
  input wire pmuswp_pkg::pmuswp_diff_s fsync_d_n,
  input wire pmuswp_pkg::pmuswp_diff_s serial_in_d,
  // readback output
  output logic serial_out_se,
  output pmuswp_pkg::pmuswp_diff_s serial_out_d,
  output logic serial_out_oe_n,
  // reset request and busy (open drain)
  input wire logic reset_req_n,
  output logic busy_n_out,
  output logic busy_n_oe_n,
  // power state of the serial logic
  output logic serial_awake,
  // trim and control values
  output logic [15:0] offset_trim,
  output logic [15:0] gain_trim,
  output logic current_sense_gain_sel,
  output logic [15:0] force_input_dac_x1,
  output logic fin_x1_update
);

  // ------------------------------------------------------------
  // link pin selection
  // ------------------------------------------------------------
  logic link_clk;
  logic link_fsync_n;
  logic link_sdi;

  // pick single-ended or differential pins
  assign link_clk = if_sel ? sclk_d_p : sclk_se;
  assign link_fsync_n = if_sel ? ~pmuswp_pkg::pair_level(~fsync_d_n)
                               : fsync_se_n;
  assign link_sdi = if_sel ? pmuswp_pkg::pair_level(serial_in_d)
                           : serial_in_se;

  // ------------------------------------------------------------
  // link clock domain
  // ------------------------------------------------------------
  logic [28:0] rx_shift_reg, rx_shift_next;
  logic [5:0] rx_cnt_reg, rx_cnt_next;
  logic seen_seq_reg, seen_seq_next;
  logic [15:0] tx_shift_reg, tx_shift_next;
  logic sdo_reg, sdo_next;
  logic link_ignore;
  logic init_busy_reg;
  logic frame_seq_reg;
  logic [15:0] rb_data_reg;

  // init flag read steady, like the frame sequence bit: it moves only
  // while busy is low and the link is quiet; a gated link clock would
  // drag a synchroniser two bits into the first frame after init
  assign link_ignore = init_busy_reg;

  // shift msb first on falling link edges; works with gated clocks
  always_comb begin
    rx_shift_next = rx_shift_reg;
    rx_cnt_next = rx_cnt_reg;
    seen_seq_next = seen_seq_reg;
    tx_shift_next = tx_shift_reg;
    sdo_next = sdo_reg;
    if (!link_fsync_n) begin
      if (seen_seq_reg != frame_seq_reg) begin
        // first edge of a new frame: fresh count and readback load
        seen_seq_next = frame_seq_reg;
        rx_cnt_next = 6'h01;
        sdo_next = rb_data_reg[15];
        tx_shift_next = {rb_data_reg[14:0], 1'b0};
      end else begin
        if (rx_cnt_reg < pmuswp_pkg::WORD_BITS_CNT) begin
          rx_cnt_next = rx_cnt_reg + 6'h01;
        end
        sdo_next = tx_shift_reg[15];
        tx_shift_next = {tx_shift_reg[14:0], 1'b0};
      end
      // longer frames push early bits out the top
      rx_shift_next = {rx_shift_reg[27:0], link_sdi};
    end
    // frame marker still tracked, but no bit counts while initialising
    if (link_ignore) begin
      rx_cnt_next = 6'h00;
    end
  end

  // link side registers
  always_ff @(negedge link_clk or posedge rst) begin
    if (rst) begin
      rx_shift_reg <= 29'h0000000;
      rx_cnt_reg <= 6'h00;
      seen_seq_reg <= 1'b0;
      tx_shift_reg <= 16'h0000;
      sdo_reg <= 1'b0;
    end else begin
      rx_shift_reg <= rx_shift_next;
      rx_cnt_reg <= rx_cnt_next;
      seen_seq_reg <= seen_seq_next;
      tx_shift_reg <= tx_shift_next;
      sdo_reg <= sdo_next;
    end
  end

  // readback drive, true and complement
  assign serial_out_se = sdo_reg;
  assign serial_out_d = '{p: sdo_reg, c: ~sdo_reg};

  // count never passes one word
  property p_rx_cnt_sat;
    @(negedge link_clk) disable iff (rst)
    rx_cnt_reg <= pmuswp_pkg::WORD_BITS_CNT;
  endproperty
  a_rx_cnt_sat: assert property (p_rx_cnt_sat)
    else $error("bit count above word length");

  // ------------------------------------------------------------
  // crossings into the reference domain
  // ------------------------------------------------------------
  logic fs_n_sync;
  logic rst_req_n_sync;

  pmuswp_sync #(
    .RST_VAL(1'b1)
  ) u_fsync_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(link_fsync_n),
    .q(fs_n_sync)
  );

  pmuswp_sync #(
    .RST_VAL(1'b0)
  ) u_rreq_sync (
    .clk(ref_clk),
    .rst(rst),
    .d(reset_req_n),
    .q(rst_req_n_sync)
  );

  // ------------------------------------------------------------
  // reference domain state
  // ------------------------------------------------------------
  pmuswp_pkg::pmuswp_state_e state_reg, state_next;
  logic [13:0] cyc_reg, cyc_next;
  logic fs_prev_reg;
  logic frame_seq_next;
  logic init_busy_next;
  logic awake_reg, awake_next;
  logic [15:0] offset_reg, offset_next;
  logic [15:0] gain_reg, gain_next;
  logic sense_gain_reg, sense_gain_next;
  logic [15:0] fin_x1_reg, fin_x1_next;
  logic fin_upd_reg, fin_upd_next;
  logic [15:0] rb_data_next;
  logic rb_pend_reg, rb_pend_next;
  logic busy_oe_n_reg, busy_oe_n_next;
  logic sdo_oe_n_reg, sdo_oe_n_next;
  logic fs_fall;
  logic fs_rise;
  logic frame_ok;
  logic wr_take;
  pmuswp_pkg::pmuswp_word_s word;

  // frame edges seen on the synchronised sync
  assign fs_fall = fs_prev_reg && !fs_n_sync;
  assign fs_rise = !fs_prev_reg && fs_n_sync;
  // link registers are quiet while sync is high, so read them here
  assign word = pmuswp_pkg::pmuswp_word_s'(rx_shift_reg);
  assign frame_ok = rx_cnt_reg == pmuswp_pkg::WORD_BITS_CNT;
  assign wr_take = fs_rise && frame_ok && (state_reg != pmuswp_pkg::ST_INIT);

  // next values for control, registers and busy timing
  always_comb begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    frame_seq_next = frame_seq_reg;
    awake_next = awake_reg;
    offset_next = offset_reg;
    gain_next = gain_reg;
    sense_gain_next = sense_gain_reg;
    fin_x1_next = fin_x1_reg;
    fin_upd_next = 1'b0;
    rb_data_next = rb_data_reg;
    rb_pend_next = rb_pend_reg;
    // wake on a falling sync
    if (fs_fall && state_reg != pmuswp_pkg::ST_INIT) begin
      awake_next = 1'b1;
    end
    if (fs_rise) begin
      // frame over: new sequence for the link, serial logic sleeps
      frame_seq_next = ~frame_seq_reg;
      awake_next = 1'b0;
    end
    if (wr_take) begin
      rb_pend_next = word.rb;
      if (word.rb) begin
        case (word.addr)
          pmuswp_pkg::ADDR_SYS_CTRL: begin
            rb_data_next = {15'h0000, sense_gain_reg};
          end
          pmuswp_pkg::ADDR_FIN_X1: rb_data_next = fin_x1_reg;
          pmuswp_pkg::ADDR_GAIN_TRIM: rb_data_next = gain_reg;
          pmuswp_pkg::ADDR_OFFSET_TRIM: rb_data_next = offset_reg;
          default: rb_data_next = 16'h0000;
        endcase
      end else begin
        case (word.addr)
          pmuswp_pkg::ADDR_SYS_CTRL: begin
            sense_gain_next = word.data[pmuswp_pkg::SYS_GAIN_SEL_POS];
          end
          pmuswp_pkg::ADDR_FIN_X1: begin
            fin_x1_next = word.data;
            fin_upd_next = 1'b1;
          end
          pmuswp_pkg::ADDR_GAIN_TRIM: gain_next = word.data;
          pmuswp_pkg::ADDR_OFFSET_TRIM: offset_next = word.data;
          default: begin
            // dac output and unknown addresses write nothing
          end
        endcase
      end
    end
    case (state_reg)
      pmuswp_pkg::ST_INIT: begin
        // registers held at defaults while initialising
        offset_next = pmuswp_pkg::OFFSET_TRIM_RST;
        gain_next = pmuswp_pkg::GAIN_TRIM_RST;
        sense_gain_next = pmuswp_pkg::SENSE_GAIN_RST;
        fin_x1_next = pmuswp_pkg::FIN_X1_RST;
        rb_data_next = 16'h0000;
        rb_pend_next = 1'b0;
        awake_next = 1'b0;
        if (cyc_reg != 14'h0000) begin
          cyc_next = cyc_reg - 14'h0001;
        end else if (rst_req_n_sync) begin
          state_next = pmuswp_pkg::ST_IDLE;
        end
      end
      pmuswp_pkg::ST_IDLE: begin
        if (wr_take) begin
          state_next = pmuswp_pkg::ST_BUSY;
          cyc_next = 14'(pmuswp_pkg::BUSY_WRITE_CYC - 1);
        end
      end
      pmuswp_pkg::ST_BUSY: begin
        if (wr_take) begin
          cyc_next = 14'(pmuswp_pkg::BUSY_WRITE_CYC - 1);
        end else if (cyc_reg != 14'h0000) begin
          cyc_next = cyc_reg - 14'h0001;
        end else begin
          state_next = pmuswp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = pmuswp_pkg::ST_INIT;
        cyc_next = 14'(INIT_CYCLES - 1);
      end
    endcase
    // a reset request restarts initialisation from idle or busy
    if (!rst_req_n_sync && state_reg != pmuswp_pkg::ST_INIT) begin
      state_next = pmuswp_pkg::ST_INIT;
      cyc_next = 14'(INIT_CYCLES - 1);
    end
  end

  // busy and readback drive follow the next state
  always_comb begin
    busy_oe_n_next = (state_next == pmuswp_pkg::ST_IDLE);
    init_busy_next = (state_next == pmuswp_pkg::ST_INIT);
    // readback driver released in init and when nothing is requested
    sdo_oe_n_next = (state_next == pmuswp_pkg::ST_INIT) || !rb_pend_next;
  end

  // reference domain registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= pmuswp_pkg::ST_INIT;
      cyc_reg <= 14'(INIT_CYCLES - 1);
      fs_prev_reg <= 1'b1;
      frame_seq_reg <= 1'b1;
      init_busy_reg <= 1'b1;
      awake_reg <= 1'b0;
      offset_reg <= pmuswp_pkg::OFFSET_TRIM_RST;
      gain_reg <= pmuswp_pkg::GAIN_TRIM_RST;
      sense_gain_reg <= pmuswp_pkg::SENSE_GAIN_RST;
      fin_x1_reg <= pmuswp_pkg::FIN_X1_RST;
      fin_upd_reg <= 1'b0;
      rb_data_reg <= 16'h0000;
      rb_pend_reg <= 1'b0;
      busy_oe_n_reg <= 1'b0;
      sdo_oe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      fs_prev_reg <= fs_n_sync;
      frame_seq_reg <= frame_seq_next;
      init_busy_reg <= init_busy_next;
      awake_reg <= awake_next;
      offset_reg <= offset_next;
      gain_reg <= gain_next;
      sense_gain_reg <= sense_gain_next;
      fin_x1_reg <= fin_x1_next;
      fin_upd_reg <= fin_upd_next;
      rb_data_reg <= rb_data_next;
      rb_pend_reg <= rb_pend_next;
      busy_oe_n_reg <= busy_oe_n_next;
      sdo_oe_n_reg <= sdo_oe_n_next;
    end
  end

  // outputs straight from flops, except busy data, which is tied low
  assign busy_n_out = 1'b0;
  assign busy_n_oe_n = busy_oe_n_reg;
  assign serial_out_oe_n = sdo_oe_n_reg;
  assign serial_awake = awake_reg;
  assign offset_trim = offset_reg;
  assign gain_trim = gain_reg;
  assign current_sense_gain_sel = sense_gain_reg;
  assign force_input_dac_x1 = fin_x1_reg;
  assign fin_x1_update = fin_upd_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_busy_hold;
    @(posedge ref_clk) disable iff (rst)
    wr_take |=> !busy_n_oe_n [*6];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy released before write completed");

  property p_busy_end;
    @(posedge ref_clk) disable iff (rst)
    wr_take ##1 (!wr_take && rst_req_n_sync) [*7] |-> busy_n_oe_n;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy held too long after write");

  property p_init_ignore;
    @(posedge ref_clk) disable iff (rst)
    state_reg == pmuswp_pkg::ST_INIT |-> !wr_take && !busy_n_oe_n;
  endproperty
  a_init_ignore: assert property (p_init_ignore)
    else $error("frame taken during initialisation");

  property p_sdo_hiz;
    @(posedge ref_clk) disable iff (rst)
    state_reg == pmuswp_pkg::ST_INIT |-> serial_out_oe_n;
  endproperty
  a_sdo_hiz: assert property (p_sdo_hiz)
    else $error("readback driven during reset");

  property p_short_frame;
    @(posedge ref_clk) disable iff (rst)
    fs_rise && rx_cnt_reg < pmuswp_pkg::WORD_BITS_CNT
      |=> $stable(gain_trim) && $stable(offset_trim);
  endproperty
  a_short_frame: assert property (p_short_frame)
    else $error("short frame changed a register");

  property p_gain_write;
    @(posedge ref_clk) disable iff (rst)
    wr_take && !word.rb && word.addr == pmuswp_pkg::ADDR_GAIN_TRIM
      |=> gain_trim == $past(word.data);
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("gain trim not updated at frame end");

  property p_dac_refused;
    @(posedge ref_clk) disable iff (rst)
    wr_take && word.addr == pmuswp_pkg::ADDR_FIN_DAC_OUT
      |=> $stable(force_input_dac_x1) && !fin_x1_update;
  endproperty
  a_dac_refused: assert property (p_dac_refused)
    else $error("dac output address wrote a register");

  property p_defaults;
    @(posedge ref_clk) disable iff (rst)
    state_reg == pmuswp_pkg::ST_INIT ##1 state_reg == pmuswp_pkg::ST_INIT
      |-> offset_trim == 16'h8000 && gain_trim == 16'hFFFF;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("trim defaults wrong during init");

  property p_wake;
    @(posedge ref_clk) disable iff (rst)
    fs_fall && state_reg != pmuswp_pkg::ST_INIT |=> serial_awake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("serial logic not woken by falling sync");

  property p_sense_gain;
    @(posedge ref_clk) disable iff (rst)
    wr_take && !word.rb && word.addr == pmuswp_pkg::ADDR_SYS_CTRL
      |=> current_sense_gain_sel == $past(word.data[0]);
  endproperty
  a_sense_gain: assert property (p_sense_gain)
    else $error("current sense gain select not written");

endmodule // pmuswp_top
`default_nettype wire

// ### dv/pmuswp_host.sv
// host model: drives serial frames and captures readback bits
`timescale 1ns/10ps
`default_nettype none
module pmuswp_host (
  // link outputs
  output logic sclk,
  output logic fsync_n,
  output logic serial_in,
  // readback input
  input wire logic serial_out
);
  logic free_run;
  logic [15:0] cap;
  // idle levels: clock stands high, sync high
  initial begin
    sclk = 1'b1;
    fsync_n = 1'b1;
    serial_in = 1'b0;
    free_run = 1'b0;
    cap = 16'h0000;
  end
  // free-running 12 ns link clock when chosen
  always #6 if (free_run) sclk = ~sclk;
  // one frame, msb first; first 16 readback bits are kept
  task automatic send(input logic [31:0] w, input int n, input bit free);
    free_run = free;
    fsync_n = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      if (free) @(posedge sclk);
      serial_in = w[i];
      if (free) @(negedge sclk);
      else #6 sclk = 1'b0;
      #5 if (i > n - 17) cap = {cap[14:0], serial_out};
      if (!free) #1 sclk = 1'b1;
    end
    #3 fsync_n = 1'b1;
    serial_in = ~serial_in; // released line shows no stale value
    if (free) @(posedge sclk) free_run = 1'b0;
  endtask
endmodule // pmuswp_host
`default_nettype wire

// ### dv/pmuswp_top_test.sv
// self-checking bench of the pmu serial write port
`timescale 1ns/10ps
`default_nettype none
module pmuswp_top_test;
  localparam int INIT_N = 20;
  localparam int LIMIT = 20000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic if_sel = 1'b0;
  logic reset_req_n = 1'b1;
  logic sclk, fsync_n, serial_in, sdo_se, oe_n, busy_oe_n, busy_o, awake, sel, upd;
  logic fs_se, sd_se, busy_w, serial_out;
  pmuswp_pkg::pmuswp_diff_s sdo_d, fs_d, sd_d;
  logic [15:0] off, gain, force_input_dac, e_off, e_gain, e_fin;
  logic e_sel;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 62;
  // unselected port sees inverted traffic; busy wire with pull-up
  assign fs_se = if_sel ? ~fsync_n : fsync_n;
  assign sd_se = if_sel ? ~serial_in : serial_in;
  assign fs_d = if_sel ? {fsync_n, ~fsync_n} : {~fsync_n, fsync_n};
  assign sd_d = if_sel ? {serial_in, ~serial_in} : {~serial_in, serial_in};
  // released readback line shows the inverse of what the flop holds
  assign serial_out = (if_sel ? (sdo_d.p & ~sdo_d.c) : sdo_se) ^ oe_n;
  assign busy_w = busy_oe_n ? 1'b1 : busy_o;
  pmuswp_host i_host (.sclk(sclk), .fsync_n(fsync_n), .serial_in(serial_in), .serial_out(serial_out));
  pmuswp_top #(.INIT_CYCLES(INIT_N)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .if_sel(if_sel), .sclk_se(sclk),
    .fsync_se_n(fs_se), .serial_in_se(sd_se), .sclk_d_p(sclk),
    .fsync_d_n(fs_d), .serial_in_d(sd_d), .serial_out_se(sdo_se),
    .serial_out_d(sdo_d), .serial_out_oe_n(oe_n),
    .reset_req_n(reset_req_n), .busy_n_out(busy_o),
    .busy_n_oe_n(busy_oe_n), .serial_awake(awake), .offset_trim(off),
    .gain_trim(gain), .current_sense_gain_sel(sel),
    .force_input_dac_x1(force_input_dac), .fin_x1_update(upd));
  // reference clock and hang guard
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      print_verdict();
    end
  end
  // compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // defaults while reset or reset request holds
  task automatic chk_dflt;
    e_off = pmuswp_pkg::OFFSET_TRIM_RST;
    e_gain = pmuswp_pkg::GAIN_TRIM_RST;
    e_sel = pmuswp_pkg::SENSE_GAIN_RST;
    e_fin = pmuswp_pkg::FIN_X1_RST;
    chk(off, 16'h8000);
    chk(gain, 16'hFFFF);
    chk(16'(sel), 16'h0001);
    chk(16'(oe_n), 16'h0001);
    chk(16'(busy_w), 16'h0000);
  endtask
  // wait for busy to be released
  task automatic wait_idle;
    for (int i = 0; i < 100 && busy_w !== 1'b1; i++) @(negedge ref_clk);
    chk(16'(busy_w), 16'h0001);
  endtask
  // frame with busy, update pulse and register checks
  task automatic frame(input logic [31:0] w, input int n, input bit free);
    logic [15:0] lo, up;
    logic good;
    lo = 16'h0000;
    up = 16'h0000;
    good = (n >= 29) || free;
    chk(16'(awake), 16'h0000);
    fork
      i_host.send(w, n, free);
      begin
        #190 chk(16'(awake), 16'h0001);
      end
    join
    for (int i = 0; i < 16; i++) begin
      @(negedge ref_clk);
      lo += 16'(busy_w === 1'b0);
      up += 16'(upd === 1'b1);
    end
    if (good && !w[28]) begin
      case (w[27:23])
        5'h00: e_sel = w[0];
        5'h01: e_fin = w[15:0];
        5'h02: e_gain = w[15:0];
        5'h03: e_off = w[15:0];
        default: ;
      endcase
    end
    chk(lo, good ? 16'h0006 : 16'h0000);
    chk(up, 16'(good && !w[28] && w[27:23] == 5'h01));
    chk(off, e_off);
    chk(gain, e_gain);
    chk(force_input_dac, e_fin);
    chk(16'(sel), 16'(e_sel));
  endtask
  // main sequence, once per interface choice
  initial begin
    logic [31:0] w;
    int n;
    for (int m = 0; m < 2; m++) begin
      @(negedge ref_clk);
      rst = 1'b1;
      if_sel = m[0];
      repeat (10) @(negedge ref_clk);
      chk_dflt();
      rst = 1'b0;
      wait_idle();
      frame({4'h0, pmuswp_pkg::ADDR_SYS_CTRL, 23'h0}, 29, 1'b0);
      for (int k = 0; k < 12; k++) begin
        w = $random(seed);
        w[28] = 1'b0;
        w[27:23] = 5'(k % 5);
        n = (k % 3 == 2) ? 28 : 29 + 3 * (k % 2);
        frame(w, n, (n != 28) && k[1]);
      end
      for (int a = 0; a < 4; a++) begin
        frame({4'h1, 5'(a), 23'h0}, 29, 1'b0);
        chk(16'(oe_n), 16'h0000);
        frame({4'h0, pmuswp_pkg::ADDR_FIN_DAC_OUT, 23'h0}, 29, 1'b0);
        chk(i_host.cap, a == 0 ? 16'(e_sel) : a == 1 ? e_fin :
            a == 2 ? e_gain : e_off);
        chk(16'(oe_n), 16'h0001);
      end
      reset_req_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk_dflt();
      i_host.send({4'h0, pmuswp_pkg::ADDR_GAIN_TRIM, 23'h1111}, 29, 1'b0);
      reset_req_n = 1'b1;
      wait_idle();
      chk(gain, 16'hFFFF);
    end
    print_verdict();
  end
  // verdict and end of run
  task automatic print_verdict;
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
endmodule // pmuswp_top_test
`default_nettype wire
